// ==== design/ipe_input_port_edge_irq.sv ====
// Purpose: Edge interrupt logic for two groups of four input pins, APB slave.
// Assumes: Pins are asynchronous to i_clock; APB master keeps the protocol.
// Notes: Zero wait state slave; read data is captured in the setup cycle.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module ipe_input_port_edge_irq (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_srst,
  // APB slave.
  input wire ipe_pkg::ipe_apb_req_type i_apb,
  output ipe_pkg::ipe_apb_rsp_type o_apb,
  // Input pins.
  input wire logic [3:0] i_input_pins_group_a,
  input wire logic [3:0] i_input_pins_group_b,
  // Interrupt and timer clock.
  output logic o_irq,
  output logic o_timer_shared_clock_pin
);

  ipe_pkg::ipe_state_type q;
  ipe_pkg::ipe_state_type d;
  logic [7:0] agree;
  logic [7:0] chg;
  logic [7:0] trig;
  logic [1:0] grp;
  logic [1:0] clr;
  logic hit;
  logic mapped;
  logic wr;
  logic setup;
  logic [15:0] idx;
  logic [3:0] wnib;
  logic [31:0] rd;

  // Bus decode; bits above the index and below the word must be zero.
  assign idx = i_apb.paddr[17:2];
  assign hit = (i_apb.paddr[19:18] == 2'h0) && (i_apb.paddr[1:0] == 2'h0);
  assign setup = i_apb.psel && !i_apb.penable;
  assign wr = i_apb.psel && i_apb.penable && i_apb.pwrite && i_apb.pstrb[0];
  assign wnib = i_apb.pwdata[3:0];

  // Read mux; narrow registers sit in the low bits, upper bits read zero.
  always_comb begin
    rd = 32'h0000_0000;
    mapped = hit;
    case (idx)
      ipe_pkg::IPE_IDX_SEL_A: rd[3:0] = q.sel[3:0];
      ipe_pkg::IPE_IDX_SEL_B: rd[3:0] = q.sel[7:4];
      ipe_pkg::IPE_IDX_POL_A: rd[3:0] = q.pol[3:0];
      ipe_pkg::IPE_IDX_POL_B: rd[3:0] = q.pol[7:4];
      ipe_pkg::IPE_IDX_DATA_A: rd[3:0] = q.filt[3:0];
      ipe_pkg::IPE_IDX_DATA_B: rd[3:0] = q.filt[7:4];
      ipe_pkg::IPE_IDX_MASK_A: rd[ipe_pkg::IPE_MASK_POS] = q.mask[0];
      ipe_pkg::IPE_IDX_MASK_B: rd[ipe_pkg::IPE_MASK_POS] = q.mask[1];
      ipe_pkg::IPE_IDX_FLAG_A: rd[ipe_pkg::IPE_FLAG_POS] = q.flag[0];
      ipe_pkg::IPE_IDX_FLAG_B: rd[ipe_pkg::IPE_FLAG_POS] = q.flag[1];
      default: mapped = 1'b0;
    endcase
  end

  // Next state. A level counts only once the second and third stage agree,
  // which filters the metastable first stage and one-cycle glitches.
  always_comb begin
    d = q;
    clr = 2'h0;
    d.s1 = {i_input_pins_group_b, i_input_pins_group_a};
    d.s2 = q.s1;
    d.s3 = q.s2;
    agree = ~(q.s2 ^ q.s3);
    chg = agree & (q.s3 ^ q.filt);
    d.filt = (q.filt & ~agree) | (q.s3 & agree);
    // New level 1 is a rising edge, taken when polarity is 0, and vice versa.
    trig = q.sel & chg & (q.s3 ^ q.pol);
    grp = {|trig[ipe_pkg::IPE_GRP_B_LSB +: 4], |trig[3:0]};
    if (wr && hit) begin
      case (idx)
        ipe_pkg::IPE_IDX_SEL_A: d.sel[3:0] = wnib;
        ipe_pkg::IPE_IDX_SEL_B: d.sel[7:4] = wnib;
        ipe_pkg::IPE_IDX_POL_A: d.pol[3:0] = wnib;
        ipe_pkg::IPE_IDX_POL_B: d.pol[7:4] = wnib;
        ipe_pkg::IPE_IDX_MASK_A: d.mask[0] = wnib[ipe_pkg::IPE_MASK_POS];
        ipe_pkg::IPE_IDX_MASK_B: d.mask[1] = wnib[ipe_pkg::IPE_MASK_POS];
        ipe_pkg::IPE_IDX_FLAG_A: clr[0] = wnib[ipe_pkg::IPE_FLAG_POS];
        ipe_pkg::IPE_IDX_FLAG_B: clr[1] = wnib[ipe_pkg::IPE_FLAG_POS];
        default: d.err = q.err; // Data registers ignore writes.
      endcase
    end
    // Set wins over clear, so an edge in the clearing cycle is kept.
    d.flag = (q.flag & ~clr) | grp;
    // A refused read returns zero beside the error flag, never a register's contents.
    if (setup) begin
      d.rdata = mapped ? rd : ipe_pkg::IPE_RDATA_RST;
      d.err = !mapped;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      q <= ipe_pkg::IPE_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs; the request stays up while any unmasked flag is set.
  assign o_irq = |(q.flag & q.mask);
  assign o_timer_shared_clock_pin = q.filt[7];
  assign o_apb = '{prdata: q.rdata, pready: 1'b1, pslverr: q.err};

  // Checks.
  property p_sel_rb;
    @(posedge i_clock) disable iff (i_srst)
    (wr && hit && idx == ipe_pkg::IPE_IDX_SEL_A) |=> (q.sel[3:0] == $past(wnib));
  endproperty
  a_sel_rb: assert property (p_sel_rb) else $error("select write lost");

  property p_unsel;
    @(posedge i_clock) disable iff (i_srst)
    (q.sel[3:0] == 4'h0 && !q.flag[0]) |=> !q.flag[0];
  endproperty
  a_unsel: assert property (p_unsel) else $error("unselected pin set flag");

  property p_rst;
    @(posedge i_clock)
    i_srst |=>
      (q.sel == 8'h00 && q.pol == 8'h00 && q.mask == 2'h0 && q.flag == 2'h0);
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");

  property p_fall;
    @(posedge i_clock) disable iff (i_srst)
    ($fell(q.filt[0]) && $past(q.sel[0] && q.pol[0])) |-> q.flag[0];
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");

  property p_rise;
    @(posedge i_clock) disable iff (i_srst)
    ($rose(q.filt[4]) && $past(q.sel[4] && !q.pol[4])) |-> q.flag[1];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");

  property p_mask;
    @(posedge i_clock) disable iff (i_srst)
    (q.mask == 2'h0) |-> !o_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq raised");

  property p_irq;
    @(posedge i_clock) disable iff (i_srst)
    (q.flag[0] && q.mask[0]) |-> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled irq missing");

  property p_w1c;
    @(posedge i_clock) disable iff (i_srst)
    (wr && hit && idx == ipe_pkg::IPE_IDX_FLAG_A && wnib[0] && !grp[0]) |=> !q.flag[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_iso;
    @(posedge i_clock) disable iff (i_srst)
    $rose(q.flag[1]) |-> $past(grp[1]);
  endproperty
  a_iso: assert property (p_iso) else $error("flag B set without B edge");

  property p_set;
    @(posedge i_clock) disable iff (i_srst)
    grp[0] |=> q.flag[0] [*1] ##0 (o_irq == q.mask[0] || q.flag[1]);
  endproperty
  a_set: assert property (p_set) else $error("edge lost or irq wrong");

  property p_rdata;
    @(posedge i_clock) disable iff (i_srst)
    (setup && hit && idx == ipe_pkg::IPE_IDX_DATA_B) |=>
      (o_apb.prdata[3:0] == $past(q.filt[7:4]));
  endproperty
  a_rdata: assert property (p_rdata) else $error("pin data read wrong");

  // Register write-back; select, polarity and mask take the low bits of the written word, pin data ignores writes.
  property p_sel_rb_b;
    @(posedge i_clock) disable iff (i_srst)
    (wr && hit && idx == ipe_pkg::IPE_IDX_SEL_B) |=> (q.sel[7:4] == $past(wnib));
  endproperty
  a_sel_rb_b: assert property (p_sel_rb_b) else $error("group B select write lost");

  property p_pol_rb_a;
    @(posedge i_clock) disable iff (i_srst)
    (wr && hit && idx == ipe_pkg::IPE_IDX_POL_A) |=> (q.pol[3:0] == $past(wnib));
  endproperty
  a_pol_rb_a: assert property (p_pol_rb_a) else $error("group A polarity write lost");

  property p_pol_rb_b;
    @(posedge i_clock) disable iff (i_srst)
    (wr && hit && idx == ipe_pkg::IPE_IDX_POL_B) |=> (q.pol[7:4] == $past(wnib));
  endproperty
  a_pol_rb_b: assert property (p_pol_rb_b) else $error("group B polarity write lost");

  property p_mask_wr_a;
    @(posedge i_clock) disable iff (i_srst)
    (wr && hit && idx == ipe_pkg::IPE_IDX_MASK_A) |=> (q.mask[0] == $past(wnib[0]));
  endproperty
  a_mask_wr_a: assert property (p_mask_wr_a) else $error("group A mask write lost");

  property p_mask_wr_b;
    @(posedge i_clock) disable iff (i_srst)
    (wr && hit && idx == ipe_pkg::IPE_IDX_MASK_B) |=> (q.mask[1] == $past(wnib[0]));
  endproperty
  a_mask_wr_b: assert property (p_mask_wr_b) else $error("group B mask write lost");

  property p_data_wr;
    @(posedge i_clock) disable iff (i_srst)
    (wr && hit && (idx == ipe_pkg::IPE_IDX_DATA_A || idx == ipe_pkg::IPE_IDX_DATA_B)) |=>
      ($stable(q.sel) && $stable(q.pol) && $stable(q.mask));
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("pin data write had effect");

  // Read data; the word is captured at the setup edge and shown in the access cycle.
  property p_rd_sel_a;
    @(posedge i_clock) disable iff (i_srst)
    (setup && hit && idx == ipe_pkg::IPE_IDX_SEL_A) |=> (o_apb.prdata == {28'h0, $past(q.sel[3:0])});
  endproperty
  a_rd_sel_a: assert property (p_rd_sel_a) else $error("select read wrong");

  property p_rd_pol_b;
    @(posedge i_clock) disable iff (i_srst)
    (setup && hit && idx == ipe_pkg::IPE_IDX_POL_B) |=> (o_apb.prdata == {28'h0, $past(q.pol[7:4])});
  endproperty
  a_rd_pol_b: assert property (p_rd_pol_b) else $error("polarity read wrong");

  property p_rd_mask_a;
    @(posedge i_clock) disable iff (i_srst)
    (setup && hit && idx == ipe_pkg::IPE_IDX_MASK_A) |=> (o_apb.prdata == {31'h0, $past(q.mask[0])});
  endproperty
  a_rd_mask_a: assert property (p_rd_mask_a) else $error("mask read wrong");

  property p_rd_flag_b;
    @(posedge i_clock) disable iff (i_srst)
    (setup && hit && idx == ipe_pkg::IPE_IDX_FLAG_B) |=> (o_apb.prdata == {31'h0, $past(q.flag[1])});
  endproperty
  a_rd_flag_b: assert property (p_rd_flag_b) else $error("flag read wrong");

  property p_rd_data_a;
    @(posedge i_clock) disable iff (i_srst)
    (setup && hit && idx == ipe_pkg::IPE_IDX_DATA_A) |=> (o_apb.prdata[3:0] == $past(q.filt[3:0]));
  endproperty
  a_rd_data_a: assert property (p_rd_data_a) else $error("group A pin read wrong");

  property p_rd_refused;
    @(posedge i_clock) disable iff (i_srst)
    (setup && !mapped) |=> (o_apb.prdata == 32'h0000_0000 && o_apb.pslverr);
  endproperty
  a_rd_refused: assert property (p_rd_refused) else $error("refused access answered"); // Refused.

  // Select gating and edge polarity.
  property p_unsel_b;
    @(posedge i_clock) disable iff (i_srst)
    (q.sel[7:4] == 4'h0 && !q.flag[1]) |=> !q.flag[1];
  endproperty
  a_unsel_b: assert property (p_unsel_b) else $error("unselected B pin set flag");

  property p_rise_a;
    @(posedge i_clock) disable iff (i_srst)
    ($rose(q.filt[0]) && $past(q.sel[0] && !q.pol[0])) |-> q.flag[0];
  endproperty
  a_rise_a: assert property (p_rise_a) else $error("group A rising edge missed");

  property p_fall_b;
    @(posedge i_clock) disable iff (i_srst)
    ($fell(q.filt[4]) && $past(q.sel[4] && q.pol[4])) |-> q.flag[1];
  endproperty
  a_fall_b: assert property (p_fall_b) else $error("group B falling edge missed");

  property p_wrong_a;
    @(posedge i_clock) disable iff (i_srst)
    ($rose(q.filt[0]) && $past(q.sel[3:0] == 4'h1 && q.pol[0] && !q.flag[0])) |-> !q.flag[0];
  endproperty
  a_wrong_a: assert property (p_wrong_a) else $error("wrong edge set flag");

  // Flags are sticky, cleared by a written one, and an edge wins over the clear.
  property p_w1c_b;
    @(posedge i_clock) disable iff (i_srst)
    (wr && hit && idx == ipe_pkg::IPE_IDX_FLAG_B && wnib[0] && !grp[1]) |=> !q.flag[1];
  endproperty
  a_w1c_b: assert property (p_w1c_b) else $error("flag B not cleared");

  property p_w0_a;
    @(posedge i_clock) disable iff (i_srst)
    (wr && hit && idx == ipe_pkg::IPE_IDX_FLAG_A && !wnib[0] && q.flag[0]) |=> q.flag[0];
  endproperty
  a_w0_a: assert property (p_w0_a) else $error("writing zero cleared flag");

  property p_hold_a;
    @(posedge i_clock) disable iff (i_srst)
    (q.flag[0] && !clr[0]) |=> q.flag[0];
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("flag A dropped by itself");

  property p_set_wins;
    @(posedge i_clock) disable iff (i_srst)
    (clr[1] && grp[1]) |=> q.flag[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("edge lost to clear");

  property p_set_masked;
    @(posedge i_clock) disable iff (i_srst)
    (grp[1] && !q.mask[1]) |=> q.flag[1];
  endproperty
  a_set_masked: assert property (p_set_masked) else $error("masked edge not flagged");

  property p_iso_a;
    @(posedge i_clock) disable iff (i_srst)
    $rose(q.flag[0]) |-> $past(grp[0]);
  endproperty
  a_iso_a: assert property (p_iso_a) else $error("flag A set without A edge");

  // Interrupt request level.
  property p_irq_b;
    @(posedge i_clock) disable iff (i_srst)
    (q.flag[1] && q.mask[1]) |-> o_irq;
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("group B irq missing");

  property p_masked_b;
    @(posedge i_clock) disable iff (i_srst)
    (!q.mask[1] && !q.flag[0]) |-> !o_irq;
  endproperty
  a_masked_b: assert property (p_masked_b) else $error("masked B raised irq");

  property p_irq_stay;
    @(posedge i_clock) disable iff (i_srst)
    (o_irq && !(wr && hit)) |=> o_irq;
  endproperty
  a_irq_stay: assert property (p_irq_stay) else $error("irq dropped without service");

  // Outputs right after reset.
  property p_rst_out;
    @(posedge i_clock)
    i_srst |=> (!o_irq && !o_apb.pslverr && o_apb.prdata == 32'h0000_0000);
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared");

  // Synchroniser chain and agreement filter.
  property p_sync;
    @(posedge i_clock) disable iff (i_srst)
    1'b1 |=> (q.s2 == $past(q.s1) && q.s3 == $past(q.s2));
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser chain broken");

  property p_filt;
    @(posedge i_clock) disable iff (i_srst)
    (q.s2 == q.s3) |=> (q.filt == $past(q.s3));
  endproperty
  a_filt: assert property (p_filt) else $error("agreed level not taken");

  property p_glitch;
    @(posedge i_clock) disable iff (i_srst)
    (q.s2[0] != q.s3[0]) |=> (q.filt[0] == $past(q.filt[0]));
  endproperty
  a_glitch: assert property (p_glitch) else $error("unsettled level taken");

  property p_timer_pin;
    @(posedge i_clock) disable iff (i_srst)
    (q.s2[7] == q.s3[7]) |=> (o_timer_shared_clock_pin == $past(q.s3[7]));
  endproperty
  a_timer_pin: assert property (p_timer_pin) else $error("timer pin level wrong");

  property p_c_flag;
    @(posedge i_clock) disable iff (i_srst)
    grp[0] ##1 o_irq;
  endproperty
  c_flag: cover property (p_c_flag);

  property p_c_both;
    @(posedge i_clock) disable iff (i_srst)
    grp == 2'h3;
  endproperty
  c_both: cover property (p_c_both);

  property p_c_race;
    @(posedge i_clock) disable iff (i_srst)
    (clr[1] && grp[1]);
  endproperty
  c_race: cover property (p_c_race);

  property p_c_err;
    @(posedge i_clock) disable iff (i_srst)
    (setup && !mapped);
  endproperty
  c_err: cover property (p_c_err);

  property p_c_fall_b;
    @(posedge i_clock) disable iff (i_srst)
    ($fell(q.filt[4]) && q.sel[4]);
  endproperty
  c_fall_b: cover property (p_c_fall_b);

endmodule

// ==== design/ipe_pkg.sv ====
// Purpose: Constants and carrier types for the input port edge interrupt block.
// Assumes: APB slave with 32-bit data, one clock, synchronous reset.
// Notes: Register indices are word indices; the byte address is four times each.
package ipe_pkg;

  // Word indices of the registers.
  localparam logic [15:0] IPE_IDX_SEL_A = 16'hFF20;
  localparam logic [15:0] IPE_IDX_DATA_A = 16'hFF21;
  localparam logic [15:0] IPE_IDX_POL_A = 16'hFF22;
  localparam logic [15:0] IPE_IDX_SEL_B = 16'hFF24;
  localparam logic [15:0] IPE_IDX_DATA_B = 16'hFF25;
  localparam logic [15:0] IPE_IDX_POL_B = 16'hFF26;
  localparam logic [15:0] IPE_IDX_MASK_A = 16'hFFE4;
  localparam logic [15:0] IPE_IDX_MASK_B = 16'hFFE5;
  localparam logic [15:0] IPE_IDX_FLAG_A = 16'hFFF4;
  localparam logic [15:0] IPE_IDX_FLAG_B = 16'hFFF5;

  // Field positions.
  localparam int IPE_FLAG_POS = 0;
  localparam int IPE_MASK_POS = 0;
  localparam int IPE_GRP_B_LSB = 4;

  // Reset values.
  localparam logic [7:0] IPE_SEL_RST = 8'h00;
  localparam logic [7:0] IPE_POL_RST = 8'h00;
  localparam logic [1:0] IPE_MASK_RST = 2'h0;
  localparam logic [1:0] IPE_FLAG_RST = 2'h0;
  localparam logic [7:0] IPE_SYNC_RST = 8'h00;
  localparam logic [31:0] IPE_RDATA_RST = 32'h0000_0000;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [19:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } ipe_apb_req_type;

  // APB answer to the master.
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ipe_apb_rsp_type;

  // Whole state of the block.
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] filt;
    logic [7:0] sel;
    logic [7:0] pol;
    logic [1:0] mask;
    logic [1:0] flag;
    logic [31:0] rdata;
    logic err;
  } ipe_state_type;

  localparam ipe_state_type IPE_STATE_RST = '{
    s1: IPE_SYNC_RST, s2: IPE_SYNC_RST, s3: IPE_SYNC_RST, filt: IPE_SYNC_RST,
    sel: IPE_SEL_RST, pol: IPE_POL_RST, mask: IPE_MASK_RST,
    flag: IPE_FLAG_RST, rdata: IPE_RDATA_RST, err: 1'b0};

endpackage

// ==== dv/ipe_key_model.sv ====
// Purpose: Key and switch model that drives the eight input pins.
// Assumes: Pull-ups make releases rise slowly; presses fall at once.
// Notes: RISE_CYC stands in for the pull-up time constant.
`timescale 1ns/1ps
module ipe_key_model #(
  parameter int RISE_CYC = 3
) (
  // Clock and requested key levels.
  input wire logic i_clock,
  input wire logic [7:0] i_target,
  // Pin levels.
  output logic [7:0] o_pins
);
  int cnt [8];

  // A rise lags by the pull-up delay, so software must wait before sampling.
  always @(posedge i_clock) begin
    for (int i = 0; i < 8; i++) begin
      if (i_target[i] === o_pins[i]) cnt[i] <= 0;
      else if (!i_target[i] || cnt[i] >= RISE_CYC) o_pins[i] <= i_target[i];
      else cnt[i] <= cnt[i] + 1;
    end
  end

  // Pins start low.
  initial o_pins = 8'h00;
endmodule

// ==== dv/ipe_input_port_edge_irq_tb.sv ====
// Purpose: Self-checking bench for the input port edge interrupt block.
// Assumes: Zero wait state APB slave; key model on the pins.
// Notes: Reads are noted in a queue and matched by a monitor.
`timescale 1ns/1ps
module ipe_input_port_edge_irq_tb;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  ipe_pkg::ipe_apb_req_type apb = '0;
  ipe_pkg::ipe_apb_rsp_type rsp;
  logic [7:0] tgt = 8'h00;
  logic [7:0] pins;
  logic irq;
  logic tpin;
  logic [3:0] strb = 4'hF;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [32:0] expq [$];
  localparam logic [15:0] SEL [2] = '{ipe_pkg::IPE_IDX_SEL_A, ipe_pkg::IPE_IDX_SEL_B};
  localparam logic [15:0] POL [2] = '{ipe_pkg::IPE_IDX_POL_A, ipe_pkg::IPE_IDX_POL_B};
  localparam logic [15:0] MSK [2] = '{ipe_pkg::IPE_IDX_MASK_A, ipe_pkg::IPE_IDX_MASK_B};
  localparam logic [15:0] FLG [2] = '{ipe_pkg::IPE_IDX_FLAG_A, ipe_pkg::IPE_IDX_FLAG_B};
  localparam logic [15:0] DAT [2] = '{ipe_pkg::IPE_IDX_DATA_A, ipe_pkg::IPE_IDX_DATA_B};

  ipe_input_port_edge_irq ipe_input_port_edge_irq_i (
    .i_clock(i_clock), .i_srst(i_srst), .i_apb(apb), .o_apb(rsp),
    .i_input_pins_group_a(pins[3:0]), .i_input_pins_group_b(pins[7:4]),
    .o_irq(irq), .o_timer_shared_clock_pin(tpin));

  ipe_key_model ipe_key_model_i (.i_clock(i_clock), .i_target(tgt), .o_pins(pins));

  // Free running clock.
  initial forever #2.5 i_clock = ~i_clock;

  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_rd(input logic [32:0] got, input logic [32:0] e);
    checks_done++;
    if (got !== e) begin
      num_errors++;
      $display("BAD %0t read %h expected %h", $time, got, e);
    end
  endtask

  task automatic chk_bit(input logic got, input logic e);
    checks_done++;
    if (got !== e) begin
      num_errors++;
      $display("BAD %0t output bit %b expected %b", $time, got, e);
    end
  endtask

  function automatic logic [19:0] a(input logic [15:0] ix);
    return {2'b00, ix, 2'b00};
  endfunction

  // Request is held until pready is seen high at a rising edge.
  task automatic xfer(input logic w, input logic [19:0] ad, input logic [31:0] d);
    @(posedge i_clock);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d, pstrb: strb};
    @(posedge i_clock);
    apb.penable <= 1'b1;
    do @(posedge i_clock); while (rsp.pready !== 1'b1);
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] ix, input logic [31:0] d);
    xfer(1'b1, a(ix), d);
  endtask

  task automatic rd(input logic [19:0] ad, input logic [32:0] e);
    expq.push_back(e);
    xfer(1'b0, ad, 32'h0000_0000);
  endtask

  // Each completed read takes the oldest note; also cuts a hang short.
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (apb.psel && apb.penable && !apb.pwrite && rsp.pready === 1'b1 && expq.size() > 0)
      chk_rd({rsp.pslverr, rsp.prdata}, expq.pop_front());
    if (cyc == 8000) begin
      num_errors++;
      wrap_up();
    end
  end

  // Main sequence.
  initial begin
    logic [7:0] t;
    logic [3:0] v;
    logic pl;
    int g;
    int p;
    void'($urandom(32'h6e9f69e2));
    repeat (2) @(posedge i_clock);
    i_srst <= 1'b0;
    t = 8'($urandom());
    tgt <= t;
    repeat (12) @(posedge i_clock);
    for (int r = 0; r < 2; r++) begin
      rd(a(SEL[r]), 33'h0);
      rd(a(POL[r]), 33'h0);
      rd(a(MSK[r]), 33'h0);
      rd(a(FLG[r]), 33'h0);
      wr(DAT[r], {28'h0, ~t[r*4 +: 4]});
      rd(a(DAT[r]), {29'h0, t[r*4 +: 4]});
      v = 4'($urandom());
      wr(SEL[r], {28'h0, v});
      rd(a(SEL[r]), {29'h0, v});
      wr(POL[r], {28'h0, ~v});
      rd(a(POL[r]), {29'h0, ~v});
      wr(SEL[r], 32'h0);
    end
    rd(20'h00100, {1'b1, 32'h0});
    rd(a(POL[0]) | 20'h00001, {1'b1, 32'h0});
    strb = 4'hE;
    wr(SEL[0], 32'h0000_000F);
    strb = 4'hF;
    rd(a(SEL[0]), 33'h0);
    // Every pin, both polarities: unselected pin, active edge, mask, clear, wrong edge.
    for (int k = 0; k < 16; k++) begin
      g = k / 8;
      p = (k / 2) % 4;
      pl = k[0];
      tgt <= pl ? 8'hFF : 8'h00;
      repeat (12) @(posedge i_clock);
      wr(POL[g], {28'h0, {4{pl}}});
      wr(SEL[g], 32'h1 << p);
      wr(MSK[g], 32'h1);
      wr(FLG[0], 32'h1);
      wr(FLG[1], 32'h1);
      tgt[g * 4 + (p ^ 1)] <= !pl;
      repeat (12) @(posedge i_clock);
      rd(a(FLG[g]), 33'h0);
      tgt[g * 4 + p] <= !pl;
      repeat (12) @(posedge i_clock);
      chk_bit(irq, 1'b1);
      rd(a(FLG[g]), 33'h1);
      rd(a(FLG[1 - g]), 33'h0);
      if (g * 4 + p == 7) chk_bit(tpin, !pl);
      wr(MSK[g], 32'h0);
      @(posedge i_clock);
      chk_bit(irq, 1'b0);
      wr(FLG[g], 32'h0);
      rd(a(FLG[g]), 33'h1);
      wr(FLG[g], 32'h1);
      rd(a(FLG[g]), 33'h0);
      tgt <= pl ? 8'hFF : 8'h00;
      repeat (12) @(posedge i_clock);
      rd(a(FLG[g]), 33'h0);
      wr(SEL[g], 32'h0);
    end
    wrap_up();
  end
endmodule
